// *** src/dac_channel.sv ***
// One converter channel: control, data byte pair, update selection and justified next code for the input latch.
`include "dac_pair_consts.svh"

module dac_channel
  import dac_pair_pkg::*;
#(
  parameter int CODE_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic hi_wr_i,
  input wire logic lo_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic timer2_ovf_i,
  input wire logic timer3_ovf_i,
  input wire logic timer4_ovf_i,
  output logic [7:0] ctrl_o,
  output logic [7:0] hi_byte_o,
  output logic [7:0] lo_byte_o,
  output logic [CODE_W-1:0] next_code_o,
  output logic load_o,
  output logic on_o
);

  logic [7:0] ctrl;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  wire update_sel_t mode = update_sel_t'(ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  wire logic [2:0] fmt = ctrl[`CTRL_FMT_HI:`CTRL_FMT_LO];

  // In write mode the latch takes the byte on the bus together with the held low byte.
  wire logic [7:0] hi_src = (mode == UPD_ON_WRITE && hi_wr_i) ? wdata_i : hi_byte;
  wire logic [15:0] src = {hi_src, lo_byte};

  wire logic timer_hit = (mode == UPD_TIMER3 && timer3_ovf_i) ||
                         (mode == UPD_TIMER4 && timer4_ovf_i) ||
                         (mode == UPD_TIMER2 && timer2_ovf_i);
  assign load_o = (mode == UPD_ON_WRITE) ? hi_wr_i : timer_hit;

  always_comb begin
    next_code_o = src[CODE_W-1:0];
    case (fmt)
      FMT_HI4: next_code_o = src[11:0];
      FMT_HI5: next_code_o = src[12:1];
      FMT_HI6: next_code_o = src[13:2];
      FMT_HI7: next_code_o = src[14:3];
      default: next_code_o = src[15:4];
    endcase
  end

  assign ctrl_o = ctrl;
  assign hi_byte_o = hi_byte;
  assign lo_byte_o = lo_byte;
  assign on_o = ctrl[`CTRL_ON_BIT];

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
      hi_byte <= `DATA_RESET;
      lo_byte <= `DATA_RESET;
    end else begin
      if (ctrl_wr_i) begin
        ctrl <= wdata_i & `CTRL_WRITE_MASK;
      end
      if (hi_wr_i) begin
        hi_byte <= wdata_i;
      end
      if (lo_wr_i) begin
        lo_byte <= wdata_i;
      end
    end
  end

endmodule : dac_channel

// *** src/dac_pair_consts.svh ***
// Register addresses, field positions, reset values and widths for the dual converter front end.
`ifndef DAC_PAIR_CONSTS_SVH
`define DAC_PAIR_CONSTS_SVH

// ==========================================================================
// Register addresses (8-bit special-function register space)
// ==========================================================================
`define ADDR_CTRL 8'hd4
`define ADDR_HI_BYTE 8'hd3
`define ADDR_LO_BYTE 8'hd2
`define PAGE_CHAN_A 8'h00
`define PAGE_CHAN_B 8'h01

// ==========================================================================
// Control register fields
// ==========================================================================
`define CTRL_ON_BIT 7
`define CTRL_MODE_HI 4
`define CTRL_MODE_LO 3
`define CTRL_FMT_HI 2
`define CTRL_FMT_LO 0
`define CTRL_WRITE_MASK 8'h9f
`define CTRL_RESET 8'h00
`define DATA_RESET 8'h00
`define CODE_RESET 12'h000
`define RDATA_IDLE 8'h00

`endif

// *** src/dac_pair_pkg.sv ***
// Types shared by the dual converter front end.
package dac_pair_pkg;

  // ==========================================================================
  // Update sources
  // ==========================================================================
  typedef enum logic [1:0] {
    UPD_ON_WRITE = 2'h0,
    UPD_TIMER3 = 2'h1,
    UPD_TIMER4 = 2'h2,
    UPD_TIMER2 = 2'h3
  } update_sel_t;

  // ==========================================================================
  // Data justification codes (top bit set means full high byte)
  // ==========================================================================
  typedef enum logic [2:0] {
    FMT_HI4 = 3'h0,
    FMT_HI5 = 3'h1,
    FMT_HI6 = 3'h2,
    FMT_HI7 = 3'h3,
    FMT_HI8 = 3'h4
  } justify_sel_t;

endpackage : dac_pair_pkg

// *** src/dual_dac_update_and_format.sv ***
// Top of the dual 12-bit converter front end on the special-function register bus.
`include "dac_pair_consts.svh"

// Behaviour
// - Two channels, each a full 12-bit code.
// - Control bit 7 enables channel, else shutdown.
// - Disabled channel output is high impedance.
// - Mode 00 updates on high byte write.
// - Mode 00 low byte write is only stored.
// - Modes 01,10,11 select timer 3,4,2 overflow.
// - Timer modes hold bytes, copy pair together.
// - Format 000: high[3:0] and whole low byte.
// - Format 001: high[4:0] and low[7:1].
// - Format 010: high[5:0] and low[7:2].
// - Format 011: high[6:0] and low[7:3].
// - Format 1xx: whole high and low[7:4].
// - Control bits 6:5 read zero, ignore writes.
// - Second channel identical with own settings.
// - Second control at same address, page 1.
module dual_dac_update_and_format
  import dac_pair_pkg::*;
#(
  parameter int CODE_W = 12,
  parameter int NUM_CHAN = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic timer2_ovf_i,
  input wire logic timer3_ovf_i,
  input wire logic timer4_ovf_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output logic [CODE_W-1:0] chan_a_code_o,
  output logic [CODE_W-1:0] chan_b_code_o,
  output logic chan_a_on_o,
  output logic chan_b_on_o,
  output logic chan_a_out_en_o,
  output logic chan_b_out_en_o
);

  localparam logic [7:0] PAGE_TAB [NUM_CHAN] = '{`PAGE_CHAN_A, `PAGE_CHAN_B};

  logic [7:0] ctrl_q [NUM_CHAN];
  logic [7:0] hi_q [NUM_CHAN];
  logic [7:0] lo_q [NUM_CHAN];
  logic [CODE_W-1:0] next_code [NUM_CHAN];
  logic load [NUM_CHAN];
  logic on [NUM_CHAN];
  logic [CODE_W-1:0] code [NUM_CHAN];
  logic [NUM_CHAN-1:0] sel_ch;
  logic [7:0] rd_mux [NUM_CHAN];

  // ==========================================================================
  // Address decode and channels
  // ==========================================================================
  wire logic is_ctrl = (sfr_addr_i == `ADDR_CTRL);
  wire logic is_hi = (sfr_addr_i == `ADDR_HI_BYTE);
  wire logic is_lo = (sfr_addr_i == `ADDR_LO_BYTE);

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign sel_ch[g] = (sfr_page_i == PAGE_TAB[g]);
      dac_channel #(
        .CODE_W(CODE_W)
      ) u_chan (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ctrl_wr_i(sfr_wr_i && sel_ch[g] && is_ctrl),
        .hi_wr_i(sfr_wr_i && sel_ch[g] && is_hi),
        .lo_wr_i(sfr_wr_i && sel_ch[g] && is_lo),
        .wdata_i(sfr_wdata_i),
        .timer2_ovf_i(timer2_ovf_i),
        .timer3_ovf_i(timer3_ovf_i),
        .timer4_ovf_i(timer4_ovf_i),
        .ctrl_o(ctrl_q[g]),
        .hi_byte_o(hi_q[g]),
        .lo_byte_o(lo_q[g]),
        .next_code_o(next_code[g]),
        .load_o(load[g]),
        .on_o(on[g])
      );
      assign rd_mux[g] = is_ctrl ? ctrl_q[g] : is_hi ? hi_q[g] : is_lo ? lo_q[g] : `RDATA_IDLE;

      // The input latch keeps updating while the channel is off so the next enable shows the latest code.
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          code[g] <= `CODE_RESET;
        end else if (load[g]) begin
          code[g] <= next_code[g];
        end
      end
    end
  endgenerate

  wire logic addr_hit = (is_ctrl || is_hi || is_lo) && (|sel_ch);
  wire logic [7:0] rd_value = sel_ch[1] ? rd_mux[1] : sel_ch[0] ? rd_mux[0] : `RDATA_IDLE;

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `RDATA_IDLE;
      sfr_hit_o <= 1'b0;
      chan_a_on_o <= 1'b0;
      chan_b_on_o <= 1'b0;
      chan_a_out_en_o <= 1'b0;
      chan_b_out_en_o <= 1'b0;
      chan_a_code_o <= `CODE_RESET;
      chan_b_code_o <= `CODE_RESET;
    end else begin
      sfr_rdata_o <= (sfr_rd_i && addr_hit) ? rd_value : `RDATA_IDLE;
      sfr_hit_o <= (sfr_rd_i || sfr_wr_i) && addr_hit;
      chan_a_on_o <= on[0];
      chan_b_on_o <= on[1];
      chan_a_out_en_o <= on[0];
      chan_b_out_en_o <= on[1];
      chan_a_code_o <= code[0];
      chan_b_code_o <= code[1];
    end
  end

endmodule : dual_dac_update_and_format

// *** verif/dac_pair_asserts.sv ***
// Port checks for the dual converter front end.
module dac_pair_asserts #(
  parameter int CODE_W = 12
) (
  input logic sys_clk_i,
  input logic rst_i,
  input logic [7:0] sfr_page_i,
  input logic [7:0] sfr_addr_i,
  input logic sfr_wr_i,
  input logic sfr_rd_i,
  input logic [7:0] sfr_wdata_i,
  input logic timer2_ovf_i,
  input logic timer3_ovf_i,
  input logic timer4_ovf_i,
  input logic [7:0] sfr_rdata_o,
  input logic sfr_hit_o,
  input logic [CODE_W-1:0] chan_a_code_o,
  input logic [CODE_W-1:0] chan_b_code_o,
  input logic chan_a_on_o,
  input logic chan_b_on_o,
  input logic chan_a_out_en_o,
  input logic chan_b_out_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire hit_ok = sfr_page_i < 8'h02 && sfr_addr_i >= 8'hd2 && sfr_addr_i <= 8'hd4;
  wire upd = sfr_wr_i && sfr_addr_i == 8'hd3 || timer2_ovf_i || timer3_ovf_i || timer4_ovf_i;
  wire ctl = sfr_wr_i && sfr_addr_i == 8'hd4;
  wire on_bit = sfr_wdata_i[7];
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_HIT: assert property ((sfr_wr_i || sfr_rd_i) && hit_ok |=> sfr_hit_o)
    else $error("no hit");
  AST_MISS: assert property (sfr_rd_i && !hit_ok |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("unmapped read answered");
  AST_GAP: assert property (sfr_rd_i && sfr_addr_i == 8'hd4 |=> sfr_rdata_o[6:5] == 2'b00)
    else $error("unused bits set");
  AST_OE: assert property (chan_a_out_en_o == chan_a_on_o && chan_b_out_en_o == chan_b_on_o)
    else $error("drive without enable");
  AST_ON_A: assert property (ctl && sfr_page_i == 8'h00 |=> ##1 chan_a_on_o == $past(on_bit, 2))
    else $error("enable a");
  AST_ON_B: assert property (ctl && sfr_page_i == 8'h01 |=> ##1 chan_b_on_o == $past(on_bit, 2))
    else $error("enable b");
  AST_HOLD_A: assert property ($changed(chan_a_code_o) |-> $past(upd, 2))
    else $error("code a moved");
  AST_HOLD_B: assert property ($changed(chan_b_code_o) |-> $past(upd, 2))
    else $error("code b moved");
  cover property (timer2_ovf_i ##2 $changed(chan_b_code_o));
  cover property (timer3_ovf_i ##2 $changed(chan_b_code_o));
  cover property (timer4_ovf_i ##2 $changed(chan_b_code_o));
endmodule : dac_pair_asserts

bind dual_dac_update_and_format dac_pair_asserts #(.CODE_W(CODE_W)) chk (.*);

// *** verif/sfr_master.sv ***
// Processor-side register bus model for the converter front end.
module sfr_master (
  input logic sys_clk_i,
  input logic [7:0] rdata_i,
  input logic hit_i,
  output logic [7:0] page_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {page_o, addr_o, wdata_o, wr_o, rd_o} = 26'h0;
  task automatic xfer(input logic w, input logic [7:0] p, a, d, output logic [7:0] q, output logic h);
    @(negedge sys_clk_i);
    {page_o, addr_o, wdata_o, wr_o, rd_o} = {p, a, d, w, !w};
    @(negedge sys_clk_i);
    q = rdata_i;
    h = hit_i;
    // Released page, address and data lines carry the inverse so a stale value cannot pose as a driven one; both strobes drop to zero.
    {page_o, addr_o, wdata_o, wr_o, rd_o} = {~p, ~a, ~d, 2'h0};
  endtask : xfer
endmodule : sfr_master

// *** verif/testbench.sv ***
// Self-checking bench for the dual converter front end.
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; $display("mismatch %s %h %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic timer2_ovf_i = 1'b0, timer3_ovf_i = 1'b0, timer4_ovf_i = 1'b0;
  logic [7:0] sfr_page_i, sfr_addr_i, sfr_wdata_i, sfr_rdata_o, q;
  logic sfr_wr_i, sfr_rd_i, sfr_hit_o, chan_a_on_o, chan_b_on_o, chan_a_out_en_o, chan_b_out_en_o, h;
  logic [11:0] chan_a_code_o, chan_b_code_o, e;
  int fails = 0, checks_done = 0, cycles = 0;
  sfr_master bus (.sys_clk_i, .rdata_i(sfr_rdata_o), .hit_i(sfr_hit_o), .page_o(sfr_page_i),
    .addr_o(sfr_addr_i), .wdata_o(sfr_wdata_i), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i));
  dual_dac_update_and_format dut (.*);
  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (++cycles == 2000) begin
      fails++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] p, a, d);
    bus.xfer(1'b1, p, a, d, q, h);
  endtask : wr
  task automatic pulse(input int t);
    @(negedge sys_clk_i);
    {timer4_ovf_i, timer3_ovf_i, timer2_ovf_i} = 3'(1 << t);
    @(negedge sys_clk_i);
    {timer4_ovf_i, timer3_ovf_i, timer2_ovf_i} = 3'h0;
    @(negedge sys_clk_i);
  endtask : pulse
  task automatic t_regs();
    for (int p = 0; p < 3; p++) begin
      for (int a = 8'hd2; a < 8'hd6; a++) begin
        bus.xfer(1'b0, 8'(p), 8'(a), 8'h00, q, h);
        `CHK("rdata", 8'h00, q)
        `CHK("hit", 1'(p < 2 && a < 8'hd5), h)
      end
    end
    `CHK("oe_a", 1'b0, chan_a_out_en_o)
    wr(8'h00, 8'hd4, 8'hff);
    bus.xfer(1'b0, 8'h00, 8'hd4, 8'h00, q, h);
    `CHK("ctrl_a", 8'h9f, q)
    `CHK("oe_a", 1'b1, chan_a_out_en_o)
    `CHK("on_a", 1'b1, chan_a_on_o)
    `CHK("on_b", 1'b0, chan_b_on_o)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_fmt();
    logic [7:0] l;
    for (int f = 0; f < 8; f++) begin
      l = 8'h6b + 8'(f);
      wr(8'h00, 8'hd4, {5'h10, f[2:0]});
      e = chan_a_code_o;
      wr(8'h00, 8'hd2, l);
      @(negedge sys_clk_i);
      `CHK("held_a", e, chan_a_code_o)
      wr(8'h00, 8'hd3, 8'h9c - 8'(f));
      @(negedge sys_clk_i);
      e = 12'({8'h9c - 8'(f), l} >> (f > 4 ? 4 : f));
      `CHK("code_a", e, chan_a_code_o)
    end
    $display("t_fmt done");
  endtask : t_fmt
  task automatic t_byte();
    wr(8'h00, 8'hd4, 8'h84);
    `CHK("hit_wr", 1'b1, h)
    wr(8'h00, 8'hd2, 8'h00);
    for (int v = 0; v < 4; v++) begin
      wr(8'h00, 8'hd3, 8'(v * 'h55));
      @(negedge sys_clk_i);
      `CHK("code8_a", {8'(v * 'h55), 4'h0}, chan_a_code_o)
    end
    bus.xfer(1'b0, 8'h00, 8'hd3, 8'h00, q, h);
    `CHK("hi_a", 8'hff, q)
    bus.xfer(1'b0, 8'h00, 8'hd2, 8'h00, q, h);
    `CHK("lo_a", 8'h00, q)
    $display("t_byte done");
  endtask : t_byte
  task automatic t_tmr();
    for (int m = 1; m < 4; m++) begin
      wr(8'h01, 8'hd4, {3'h4, 2'(m), 3'h4});
      e = chan_b_code_o;
      wr(8'h01, 8'hd2, 8'hf0);
      wr(8'h01, 8'hd3, 8'h40 + 8'(m));
      pulse((m + 1) % 3);
      `CHK("held_b", e, chan_b_code_o)
      pulse(m % 3);
      `CHK("code_b", {8'h40 + 8'(m), 4'hf}, chan_b_code_o)
    end
    `CHK("on_b", 1'b1, chan_b_on_o)
    `CHK("oe_b", 1'b1, chan_b_out_en_o)
    bus.xfer(1'b0, 8'h01, 8'hd4, 8'h00, q, h);
    `CHK("ctrl_b", 8'h9c, q)
    wr(8'h01, 8'hd4, 8'h00);
    @(negedge sys_clk_i);
    `CHK("oe_b", 1'b0, chan_b_out_en_o)
    `CHK("on_b", 1'b0, chan_b_on_o)
    `CHK("on_a", 1'b1, chan_a_on_o)
    $display("t_tmr done");
  endtask : t_tmr
  task automatic close_out();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_regs();
    t_fmt();
    t_byte();
    t_tmr();
    close_out();
  end
endmodule : testbench
